// >>> include/bec_pkg.sv
package bec_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned BIT_CNT_W     = 32;
  localparam int unsigned ERR_CNT_W     = 24;
  localparam int unsigned INJ_CNT_W     = 10;
  localparam int unsigned RATE_W        = 4;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_BIT_CNT0   = 8'he3;
  localparam logic [7:0] OFS_BIT_CNT1   = 8'he4;
  localparam logic [7:0] OFS_BIT_CNT2   = 8'he5;
  localparam logic [7:0] OFS_BIT_CNT3   = 8'he6;
  localparam logic [7:0] OFS_ERR_CNT0   = 8'he7;
  localparam logic [7:0] OFS_ERR_CNT1   = 8'he8;
  localparam logic [7:0] OFS_ERR_CNT2   = 8'he9;
  localparam logic [7:0] OFS_PATH_CTL   = 8'hea;
  localparam logic [7:0] OFS_RATE_CTL   = 8'heb;
  localparam logic [7:0] OFS_INJ_LOW    = 8'hec;
  localparam logic [7:0] OFS_INJ_HIGH   = 8'hed;
  localparam logic [7:0] OFS_LEFT_LOW   = 8'hee;
  localparam logic [7:0] OFS_LEFT_HIGH  = 8'hef;
  localparam logic [7:0] OFS_LOOP_CTL   = 8'hf0;
  localparam logic [7:0] OFS_CNT_CTL    = 8'hf1;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int unsigned BIT_ENABLE    = 0;
  localparam int unsigned BIT_DIR       = 1;
  localparam int unsigned BIT_TX_UNFR   = 3;
  localparam int unsigned BIT_ALIGN     = 4;
  localparam int unsigned BIT_RX_UNFR   = 6;
  localparam int unsigned BIT_CONST     = 4;
  localparam int unsigned BIT_LOAD      = 7;
  localparam int unsigned BIT_LOOPBACK  = 0;
  localparam int unsigned BIT_LATCH     = 0;
  localparam logic [7:0] PATH_MASK      = 8'h5b;
  localparam logic [7:0] RATE_MASK      = 8'h9f;
  localparam logic [7:0] INJ_HIGH_MASK  = 8'h03;
  localparam logic [7:0] LOOP_MASK      = 8'h01;
  localparam logic [7:0] CNT_CTL_MASK   = 8'h01;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // ----------------------------------------
  // Pattern and insertion rate
  // ----------------------------------------
  localparam int unsigned LFSR_W        = 15;
  localparam int unsigned LFSR_TAP_A    = 14;
  localparam int unsigned LFSR_TAP_B    = 13;
  localparam logic [14:0] LFSR_SEED     = 15'h7fff;
  localparam int unsigned RATE_SHIFT    = 3;
  localparam int unsigned RATE_CNT_W    = 18;
  localparam logic [3:0] RATE_OFF       = 4'h0;

endpackage : bec_pkg

// >>> design/bec_bert_core.sv
`timescale 1ns/1ps
// Functional notes
// - Received-bit count is 32 bits over four bytes, least significant byte lowest.
// - Error count is 24 bits over three bytes, least significant byte lowest.
// - Receive unframed select 1 feeds frame-bit data to checker; 0 withholds it.
// - Transmit unframed select 1 drives pattern into frame bit; 0 leaves it.
// - Rising align control byte-aligns generated pattern to transmit byte boundaries.
// - Direction 0 sends toward line transmitter and checks line receiver data.
// - Direction 1 sends on system receive output, checks system transmit input.
// - In line direction pattern may loop back through framer loopback.
// - Tester works only while enabled; disable stops generation and checking.
// - Rising load bit moves programmed count into insertion logic two cycles later.
// - Constant mode with nonzero rate ignores count and inserts continuously.
// - Constant bit 0 inserts only the programmed number of errors.
// - Rate 0 inserts none; 1..15 give one per 16 up to 262,144 bits.
// - Programmed count is 10 bits: low byte plus bits 1:0 of high.
// - Remaining-errors 10-bit value readable by host at any time.
// - Rising latch control copies running counts out and clears internal counters.
module bec_bert_core #(
  parameter int unsigned BIT_CNT_W = bec_pkg::BIT_CNT_W,
  parameter int unsigned ERR_CNT_W = bec_pkg::ERR_CNT_W,
  parameter int unsigned INJ_CNT_W = bec_pkg::INJ_CNT_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_i,
  input  wire logic [bec_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [bec_pkg::DATA_W-1:0]  reg_wr_data_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [bec_pkg::DATA_W-1:0]  reg_rd_data_o,
  input  wire logic                        tx_bit_strobe_i,
  input  wire logic                        tx_frame_bit_i,
  input  wire logic                        tx_byte_start_i,
  input  wire logic                        rx_bit_strobe_i,
  input  wire logic                        rx_frame_bit_i,
  input  wire logic                        line_rx_pos_i,
  input  wire logic                        sys_tx_serial_in_i,
  output logic                             line_tx_pos_o,
  output logic                             line_tx_drive_o,
  output logic                             sys_rx_serial_out_o,
  output logic                             sys_rx_drive_o,
  output logic                             framer_loopback_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] bec_byte_of(input logic [31:0] value,
                                             input int unsigned idx);
    bec_byte_of = value[idx*8 +: 8];
  endfunction : bec_byte_of

  function automatic logic [bec_pkg::RATE_CNT_W-1:0] bec_period_last(
    input logic [bec_pkg::RATE_W-1:0] rate);
    logic [bec_pkg::RATE_CNT_W:0] one_hot;
    one_hot = '0;
    // Index needs five bits: rate 15 plus the shift would wrap in four
    one_hot[5'(rate) + 5'(bec_pkg::RATE_SHIFT)] = 1'b1;
    bec_period_last = bec_pkg::RATE_CNT_W'(one_hot - 1'b1);
  endfunction : bec_period_last

  function automatic logic bec_lfsr_fb(input logic [bec_pkg::LFSR_W-1:0] s);
    bec_lfsr_fb = s[bec_pkg::LFSR_TAP_A] ^ s[bec_pkg::LFSR_TAP_B];
  endfunction : bec_lfsr_fb

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]                      path_ctl_ff;
  logic [7:0]                      rate_ctl_ff;
  logic [7:0]                      inj_low_ff;
  logic [7:0]                      inj_high_ff;
  logic [7:0]                      loop_ctl_ff;
  logic [7:0]                      cnt_ctl_ff;
  logic                            load_prev_ff;
  logic                            load_pulse_ff;
  logic                            align_prev_ff;
  logic                            latch_prev_ff;
  logic                            align_pend_ff;
  logic [bec_pkg::LFSR_W-1:0]      gen_lfsr_ff;
  logic [bec_pkg::LFSR_W-1:0]      chk_lfsr_ff;
  logic [bec_pkg::RATE_CNT_W-1:0]  rate_cnt_ff;
  logic [INJ_CNT_W-1:0]            left_ff;
  logic [BIT_CNT_W-1:0]            bit_cnt_ff;
  logic [ERR_CNT_W-1:0]            err_cnt_ff;
  logic [BIT_CNT_W-1:0]            bit_hold_ff;
  logic [ERR_CNT_W-1:0]            err_hold_ff;
  logic [bec_pkg::DATA_W-1:0]      rd_data_ff;
  logic                            line_tx_ff;
  logic                            line_drive_ff;
  logic                            sys_tx_ff;
  logic                            sys_drive_ff;
  logic                            loopback_ff;
  logic [bec_pkg::DATA_W-1:0]      nxt_rd_data;

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic                            enable;
  logic                            dir_sys;
  logic [bec_pkg::RATE_W-1:0]      rate;
  logic                            constant_mode;
  logic                            gen_step;
  logic                            rate_hit;
  logic                            insert;
  logic                            gen_bit;
  logic                            check_step;
  logic                            rx_bit;
  logic                            rx_error;
  logic                            latch_rise;

  assign enable        = path_ctl_ff[bec_pkg::BIT_ENABLE];
  assign dir_sys       = path_ctl_ff[bec_pkg::BIT_DIR];
  assign rate          = rate_ctl_ff[bec_pkg::RATE_W-1:0];
  // Continuous only with a real rate; rate zero overrides everything
  assign constant_mode = rate_ctl_ff[bec_pkg::BIT_CONST] && (rate != bec_pkg::RATE_OFF);
  // Generator advances only on bits it sources; paused while awaiting alignment
  assign gen_step      = enable && tx_bit_strobe_i && !align_pend_ff
                         && (!tx_frame_bit_i || path_ctl_ff[bec_pkg::BIT_TX_UNFR]);
  assign rate_hit      = (rate != bec_pkg::RATE_OFF)
                         && (rate_cnt_ff == bec_period_last(rate));
  assign insert        = gen_step && rate_hit
                         && (constant_mode || (left_ff != '0));
  assign gen_bit       = bec_lfsr_fb(gen_lfsr_ff) ^ insert;
  assign rx_bit        = dir_sys ? sys_tx_serial_in_i : line_rx_pos_i;
  assign check_step    = enable && rx_bit_strobe_i
                         && (!rx_frame_bit_i || path_ctl_ff[bec_pkg::BIT_RX_UNFR]);
  assign rx_error      = check_step && (rx_bit != bec_lfsr_fb(chk_lfsr_ff));
  assign latch_rise    = cnt_ctl_ff[bec_pkg::BIT_LATCH] && !latch_prev_ff;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      path_ctl_ff <= bec_pkg::RESET_BYTE;
      rate_ctl_ff <= bec_pkg::RESET_BYTE;
      inj_low_ff  <= bec_pkg::RESET_BYTE;
      inj_high_ff <= bec_pkg::RESET_BYTE;
      loop_ctl_ff <= bec_pkg::RESET_BYTE;
      cnt_ctl_ff  <= bec_pkg::RESET_BYTE;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == bec_pkg::OFS_PATH_CTL)
      begin
        path_ctl_ff <= reg_wr_data_i & bec_pkg::PATH_MASK;
      end
      else if (reg_addr_i == bec_pkg::OFS_RATE_CTL)
      begin
        rate_ctl_ff <= reg_wr_data_i & bec_pkg::RATE_MASK;
      end
      else if (reg_addr_i == bec_pkg::OFS_INJ_LOW)
      begin
        inj_low_ff <= reg_wr_data_i;
      end
      else if (reg_addr_i == bec_pkg::OFS_INJ_HIGH)
      begin
        inj_high_ff <= reg_wr_data_i & bec_pkg::INJ_HIGH_MASK;
      end
      else if (reg_addr_i == bec_pkg::OFS_LOOP_CTL)
      begin
        loop_ctl_ff <= reg_wr_data_i & bec_pkg::LOOP_MASK;
      end
      else if (reg_addr_i == bec_pkg::OFS_CNT_CTL)
      begin
        cnt_ctl_ff <= reg_wr_data_i & bec_pkg::CNT_CTL_MASK;
      end
    end
  end

  // ----------------------------------------
  // Edge detection of control bits
  // ----------------------------------------
  // Level bits: host must return to 0 before another edge counts
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      load_prev_ff  <= 1'b0;
      load_pulse_ff <= 1'b0;
      align_prev_ff <= 1'b0;
      latch_prev_ff <= 1'b0;
    end
    else
    begin
      load_prev_ff  <= rate_ctl_ff[bec_pkg::BIT_LOAD];
      load_pulse_ff <= rate_ctl_ff[bec_pkg::BIT_LOAD] && !load_prev_ff;
      align_prev_ff <= path_ctl_ff[bec_pkg::BIT_ALIGN];
      latch_prev_ff <= cnt_ctl_ff[bec_pkg::BIT_LATCH];
    end
  end

  // ----------------------------------------
  // Byte alignment
  // ----------------------------------------
  // Holds the generator until the next formatter byte boundary
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      align_pend_ff <= 1'b0;
    end
    else if (path_ctl_ff[bec_pkg::BIT_ALIGN] && !align_prev_ff)
    begin
      align_pend_ff <= 1'b1;
    end
    else if (tx_byte_start_i)
    begin
      align_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pattern generator
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gen_lfsr_ff <= bec_pkg::LFSR_SEED;
    end
    else if (gen_step)
    begin
      // Inserted errors flip the output only, so the pattern stays intact
      gen_lfsr_ff <= {gen_lfsr_ff[bec_pkg::LFSR_W-2:0], bec_lfsr_fb(gen_lfsr_ff)};
    end
  end

  // ----------------------------------------
  // Error insertion rate and remaining count
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rate_cnt_ff <= '0;
    end
    else if (rate == bec_pkg::RATE_OFF)
    begin
      rate_cnt_ff <= '0;
    end
    else if (gen_step)
    begin
      rate_cnt_ff <= rate_hit ? '0 : rate_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      left_ff <= '0;
    end
    else if (load_pulse_ff)
    begin
      left_ff <= INJ_CNT_W'({inj_high_ff[1:0], inj_low_ff});
    end
    else if (insert && !constant_mode)
    begin
      left_ff <= left_ff - 1'b1;
    end
  end

  // ----------------------------------------
  // Transmit path steering
  // ----------------------------------------
  // Drive flags update per bit time so the framer owns skipped frame bits
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      line_tx_ff    <= 1'b0;
      line_drive_ff <= 1'b0;
      sys_tx_ff     <= 1'b0;
      sys_drive_ff  <= 1'b0;
    end
    else if (!enable)
    begin
      line_drive_ff <= 1'b0;
      sys_drive_ff  <= 1'b0;
    end
    else if (tx_bit_strobe_i)
    begin
      line_drive_ff <= gen_step && !dir_sys;
      sys_drive_ff  <= gen_step && dir_sys;
      if (gen_step && !dir_sys)
      begin
        line_tx_ff <= gen_bit;
      end
      if (gen_step && dir_sys)
      begin
        sys_tx_ff <= gen_bit;
      end
    end
    else
    begin
      // Direction change releases the old side at once, not at the next strobe
      line_drive_ff <= line_drive_ff && !dir_sys;
      sys_drive_ff  <= sys_drive_ff && dir_sys;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      loopback_ff <= 1'b0;
    end
    else
    begin
      loopback_ff <= loop_ctl_ff[bec_pkg::BIT_LOOPBACK] && enable && !dir_sys;
    end
  end

  // ----------------------------------------
  // Pattern checker
  // ----------------------------------------
  // Self-synchronising: received bits seed the local predictor
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      chk_lfsr_ff <= bec_pkg::LFSR_SEED;
    end
    else if (check_step)
    begin
      chk_lfsr_ff <= {chk_lfsr_ff[bec_pkg::LFSR_W-2:0], rx_bit};
    end
  end

  // ----------------------------------------
  // Bit and error counters
  // ----------------------------------------
  // A bit arriving with the latch edge starts the new period, not lost
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bit_cnt_ff  <= '0;
      err_cnt_ff  <= '0;
      bit_hold_ff <= '0;
      err_hold_ff <= '0;
    end
    else if (latch_rise)
    begin
      bit_hold_ff <= bit_cnt_ff;
      err_hold_ff <= err_cnt_ff;
      bit_cnt_ff  <= BIT_CNT_W'(check_step);
      err_cnt_ff  <= ERR_CNT_W'(rx_error);
    end
    else
    begin
      if (check_step)
      begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
      if (rx_error)
      begin
        err_cnt_ff <= err_cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb
  begin
    nxt_rd_data = bec_pkg::RESET_BYTE;
    if (reg_addr_i == bec_pkg::OFS_BIT_CNT0)
    begin
      nxt_rd_data = bec_byte_of(32'(bit_hold_ff), 0);
    end
    else if (reg_addr_i == bec_pkg::OFS_BIT_CNT1)
    begin
      nxt_rd_data = bec_byte_of(32'(bit_hold_ff), 1);
    end
    else if (reg_addr_i == bec_pkg::OFS_BIT_CNT2)
    begin
      nxt_rd_data = bec_byte_of(32'(bit_hold_ff), 2);
    end
    else if (reg_addr_i == bec_pkg::OFS_BIT_CNT3)
    begin
      nxt_rd_data = bec_byte_of(32'(bit_hold_ff), 3);
    end
    else if (reg_addr_i == bec_pkg::OFS_ERR_CNT0)
    begin
      nxt_rd_data = bec_byte_of(32'(err_hold_ff), 0);
    end
    else if (reg_addr_i == bec_pkg::OFS_ERR_CNT1)
    begin
      nxt_rd_data = bec_byte_of(32'(err_hold_ff), 1);
    end
    else if (reg_addr_i == bec_pkg::OFS_ERR_CNT2)
    begin
      nxt_rd_data = bec_byte_of(32'(err_hold_ff), 2);
    end
    else if (reg_addr_i == bec_pkg::OFS_PATH_CTL)
    begin
      nxt_rd_data = path_ctl_ff;
    end
    else if (reg_addr_i == bec_pkg::OFS_RATE_CTL)
    begin
      nxt_rd_data = rate_ctl_ff;
    end
    else if (reg_addr_i == bec_pkg::OFS_INJ_LOW)
    begin
      nxt_rd_data = inj_low_ff;
    end
    else if (reg_addr_i == bec_pkg::OFS_INJ_HIGH)
    begin
      nxt_rd_data = inj_high_ff;
    end
    else if (reg_addr_i == bec_pkg::OFS_LEFT_LOW)
    begin
      nxt_rd_data = bec_byte_of(32'(left_ff), 0);
    end
    else if (reg_addr_i == bec_pkg::OFS_LEFT_HIGH)
    begin
      nxt_rd_data = bec_byte_of(32'(left_ff), 1);
    end
    else if (reg_addr_i == bec_pkg::OFS_LOOP_CTL)
    begin
      nxt_rd_data = loop_ctl_ff;
    end
    else if (reg_addr_i == bec_pkg::OFS_CNT_CTL)
    begin
      nxt_rd_data = cnt_ctl_ff;
    end
  end

  // Data stands one cycle only, zero otherwise
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_data_ff <= bec_pkg::RESET_BYTE;
    end
    else
    begin
      rd_data_ff <= reg_rd_i ? nxt_rd_data : bec_pkg::RESET_BYTE;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rd_data_o       = rd_data_ff;
  assign line_tx_pos_o       = line_tx_ff;
  assign line_tx_drive_o     = line_drive_ff;
  assign sys_rx_serial_out_o = sys_tx_ff;
  assign sys_rx_drive_o      = sys_drive_ff;
  assign framer_loopback_o   = loopback_ff;

endmodule : bec_bert_core

// >>> testbench/bec_line_model.sv
`timescale 1ns/1ps
module bec_line_model (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic line_tx_pos_i,
  input  wire logic sys_rx_serial_out_i,
  input  wire logic sys_rx_drive_i,
  input  wire logic framer_loopback_i,
  output logic      tx_bit_strobe_o,
  output logic      tx_frame_bit_o,
  output logic      tx_byte_start_o,
  output logic      rx_bit_strobe_o,
  output logic      rx_frame_bit_o,
  output logic      line_rx_pos_o,
  output logic      sys_tx_serial_in_o
);
  // ----------------------------------------
  // Bit timing: eight clocks a bit, 193 bits a frame
  // ----------------------------------------
  logic [2:0] phase_ff;
  logic [7:0] bit_idx_ff;

  assign tx_bit_strobe_o = (phase_ff == 3'h0);
  assign rx_bit_strobe_o = (phase_ff == 3'h4);
  assign tx_frame_bit_o  = (bit_idx_ff == 8'h00);
  assign rx_frame_bit_o  = (bit_idx_ff == 8'h00);
  assign tx_byte_start_o = tx_bit_strobe_o && (bit_idx_ff[2:0] == 3'h1);

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_ff           <= 3'h0;
      bit_idx_ff         <= 8'h00;
      line_rx_pos_o      <= 1'b0;
      sys_tx_serial_in_o <= 1'b0;
    end
    else
    begin
      phase_ff <= phase_ff + 3'h1;
      if (phase_ff == 3'h7)
        bit_idx_ff <= (bit_idx_ff == 8'd192) ? 8'h00 : bit_idx_ff + 8'h01;
      // Undriven returns toggle so stale data never looks valid
      if (phase_ff == 3'h2)
      begin
        line_rx_pos_o      <= framer_loopback_i ? line_tx_pos_i : ~line_rx_pos_o;
        sys_tx_serial_in_o <= sys_rx_drive_i ? sys_rx_serial_out_i : ~sys_tx_serial_in_o;
      end
    end
  end
endmodule : bec_line_model

// >>> testbench/bec_bert_core_chk.sv
`timescale 1ns/1ps
module bec_bert_core_chk (
  input wire logic                       ref_clk_i,
  input wire logic                       reset_i,
  input wire logic [bec_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                       reg_rd_i,
  input wire logic [bec_pkg::DATA_W-1:0] reg_rd_data_o,
  input wire logic                       tx_bit_strobe_i,
  input wire logic                       line_tx_pos_o,
  input wire logic                       line_tx_drive_o,
  input wire logic                       sys_rx_serial_out_o,
  input wire logic                       sys_rx_drive_o,
  input wire logic                       framer_loopback_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rd_data_o == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property ($past(reg_rd_i) && ($past(reg_addr_i) < 8'he3 ||
    $past(reg_addr_i) > 8'hf1) |-> reg_rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  left_resv_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'hef
    |-> reg_rd_data_o[7:2] == 6'h00) else $error("left count high bits set");
  count_resv_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'hed
    |-> reg_rd_data_o[7:2] == 6'h00) else $error("count high bits set");
  path_resv_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'hea
    |-> (reg_rd_data_o & 8'ha4) == 8'h00) else $error("path reserved bits set");
  drive_excl_a: assert property (!(line_tx_drive_o && sys_rx_drive_o))
    else $error("both directions driven");
  line_step_a: assert property ($changed(line_tx_pos_o) |-> $past(tx_bit_strobe_i))
    else $error("line data moved off strobe");
  sys_step_a: assert property ($changed(sys_rx_serial_out_o) |-> $past(tx_bit_strobe_i))
    else $error("system data moved off strobe");
  drive_rise_a: assert property ($rose(line_tx_drive_o) || $rose(sys_rx_drive_o)
    |-> $past(tx_bit_strobe_i)) else $error("drive rose off strobe");
  loop_dir_a: assert property (framer_loopback_o |-> !sys_rx_drive_o)
    else $error("loopback in system direction");
endmodule : bec_bert_core_chk

bind bec_bert_core bec_bert_core_chk i_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rd_data_o(reg_rd_data_o), .tx_bit_strobe_i(tx_bit_strobe_i),
  .line_tx_pos_o(line_tx_pos_o), .line_tx_drive_o(line_tx_drive_o),
  .sys_rx_serial_out_o(sys_rx_serial_out_o), .sys_rx_drive_o(sys_rx_drive_o),
  .framer_loopback_o(framer_loopback_o));

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, wr_data = 8'h00, rd_data, path_sh = 8'h00;
  logic tx_stb, tx_frm, tx_byte, rx_stb, rx_frm, line_rx, sys_tx;
  logic line_tx, line_drv, sys_rx, sys_drv, loop_req;
  int failures = 0, compares = 0, seen_bits = 0;
  logic [31:0] v, big, cnt;
  int r;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (rx_stb && path_sh[0] && (path_sh[6] || !rx_frm)) seen_bits <= seen_bits + 1;

  bec_bert_core i_dut (.ref_clk_i(ref_clk), .reset_i(reset), .reg_addr_i(reg_addr),
    .reg_wr_data_i(wr_data), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rd_data_o(rd_data),
    .tx_bit_strobe_i(tx_stb), .tx_frame_bit_i(tx_frm), .tx_byte_start_i(tx_byte),
    .rx_bit_strobe_i(rx_stb), .rx_frame_bit_i(rx_frm), .line_rx_pos_i(line_rx),
    .sys_tx_serial_in_i(sys_tx), .line_tx_pos_o(line_tx), .line_tx_drive_o(line_drv),
    .sys_rx_serial_out_o(sys_rx), .sys_rx_drive_o(sys_drv), .framer_loopback_o(loop_req));
  bec_line_model i_line (.ref_clk_i(ref_clk), .reset_i(reset), .line_tx_pos_i(line_tx),
    .sys_rx_serial_out_i(sys_rx), .sys_rx_drive_i(sys_drv), .framer_loopback_i(loop_req),
    .tx_bit_strobe_o(tx_stb), .tx_frame_bit_o(tx_frm), .tx_byte_start_o(tx_byte),
    .rx_bit_strobe_o(rx_stb), .rx_frame_bit_o(rx_frm), .line_rx_pos_o(line_rx),
    .sys_tx_serial_in_o(sys_tx));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == bec_pkg::OFS_PATH_CTL) path_sh = d & bec_pkg::PATH_MASK;
    reg_addr <= a;
    wr_data  <= d;
    reg_wr   <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rdn(input logic [7:0] a, input int n, output logic [31:0] val);
    val = 32'h0000_0000;
    for (int i = 0; i < n; i++)
    begin
      reg_addr <= a + i[7:0];
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 val[8*i +: 8] = rd_data;
      @(posedge ref_clk);
    end
  endtask : rdn

  // Latch well clear of a receive strobe so the split point is exact
  task automatic latch(output logic [31:0] nb);
    do begin @(posedge ref_clk); #1; end while (!rx_stb);
    @(posedge ref_clk);
    #1 nb = seen_bits;
    seen_bits = 0;
    wr(bec_pkg::OFS_CNT_CTL, 8'h01);
    wr(bec_pkg::OFS_CNT_CTL, 8'h00);
  endtask : latch

  task automatic finish_period(input int n, input int lo, input int hi);
    logic [31:0] nb, e;
    repeat (n * 8) @(posedge ref_clk);
    latch(nb);
    rdn(bec_pkg::OFS_BIT_CNT0, 4, e);
    chk(e, nb, "bit count");
    rdn(bec_pkg::OFS_ERR_CNT0, 3, e);
    chk(32'(e >= lo && e <= hi), 32'h1, "error count");
  endtask : finish_period

  task automatic drives(input logic ln, input logic sy, input logic lp);
    #1 chk({line_drv, sys_drv, loop_req}, {ln, sy, lp}, "drive flags");
  endtask : drives

  function automatic int inserts(input int rate, input int nbits);
    return nbits >> (rate + 3);
  endfunction : inserts

  task automatic finish_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    #(60000 * 100);
    failures++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    void'($urandom(69));
    @(posedge ref_clk);
    for (int a = 8'he3; a <= 8'hf1; a++)
    begin
      rdn(a[7:0], 1, v);
      chk(v, 32'h0, "reset value");
    end
    rdn(8'($urandom_range(8'he2)), 1, v);
    chk(v, 32'h0, "unmapped read");
    for (int i = 0; i < 5; i++)
    begin
      logic [7:0] ra, rm, d;
      ra = (i == 4) ? bec_pkg::OFS_LOOP_CTL : 8'hea + i[7:0];
      rm = (i == 4) ? bec_pkg::LOOP_MASK : (i == 0) ? bec_pkg::PATH_MASK :
           (i == 1) ? bec_pkg::RATE_MASK : (i == 3) ? bec_pkg::INJ_HIGH_MASK : 8'hff;
      d = 8'($urandom);
      wr(ra, d);
      rdn(ra, 1, v);
      chk(v, {24'h0, d & rm}, "read back");
      wr(ra, 8'h00);
    end
    big = {22'h0, 2'b10, 8'($urandom)};
    wr(bec_pkg::OFS_INJ_LOW, big[7:0]);
    wr(bec_pkg::OFS_INJ_HIGH, big[15:8]);
    wr(bec_pkg::OFS_RATE_CTL, 8'h80);
    // Count lands one edge after wr returns
    @(posedge ref_clk);
    rdn(bec_pkg::OFS_LEFT_LOW, 2, v);
    chk(v, big, "loaded count");
    cnt = 32'($urandom_range(8, 1));
    wr(bec_pkg::OFS_INJ_LOW, cnt[7:0]);
    wr(bec_pkg::OFS_INJ_HIGH, 8'h00);
    rdn(bec_pkg::OFS_LEFT_LOW, 2, v);
    chk(v, big, "no reload without rise");
    wr(bec_pkg::OFS_RATE_CTL, 8'h00);
    wr(bec_pkg::OFS_RATE_CTL, 8'h80);
    @(posedge ref_clk);
    rdn(bec_pkg::OFS_LEFT_LOW, 2, v);
    chk(v, cnt, "reloaded count");
    wr(bec_pkg::OFS_LOOP_CTL, 8'h01);
    wr(bec_pkg::OFS_PATH_CTL, 8'h01);
    repeat (40 * 8) @(posedge ref_clk);
    drives(1'b1, 1'b0, 1'b1);
    latch(v);
    finish_period(100, 0, 0);
    latch(v);
    wr(bec_pkg::OFS_RATE_CTL, 8'h81);
    finish_period(200, 3 * cnt, 3 * cnt);
    rdn(bec_pkg::OFS_LEFT_LOW, 2, v);
    chk(v, 32'h0, "left after counted run");
    wr(bec_pkg::OFS_RATE_CTL, 8'h00);
    wr(bec_pkg::OFS_PATH_CTL, 8'h03);
    repeat (40 * 8) @(posedge ref_clk);
    drives(1'b0, 1'b1, 1'b0);
    latch(v);
    finish_period(100, 0, 0);
    wr(bec_pkg::OFS_PATH_CTL, 8'h59);
    repeat (40 * 8) @(posedge ref_clk);
    latch(v);
    r = $urandom_range(3, 1);
    wr(bec_pkg::OFS_RATE_CTL, 8'h10 | 8'(r));
    finish_period(512, 3 * inserts(r, 512) - 3, 3 * inserts(r, 512) + 3);
    rdn(bec_pkg::OFS_LEFT_LOW, 2, v);
    chk(v, 32'h0, "count ignored in constant mode");
    wr(bec_pkg::OFS_PATH_CTL, 8'h00);
    drives(1'b0, 1'b0, 1'b0);
    finish_test();
  end
endmodule : tb
